// ### amc_dev.sv
// Device end: monitoring converter sequencer, filters and status registers
//
// Contract
// - Results are 7-bit codes read over registers
// - Convert only while the device is active
// - Loop order: batt, temp, batt, low, batt, high
// - Each result lands in its own status register (code: gate codes share one word, extra sources share one)
// - Extra select picks current, regulator or buck
// - Host requests; exactly one extra conversion inserted
// - Running conversion finishes before extra starts
// - Extra result stored and ready flag set
// - Loop resumes at the interrupted pending slot
// - Moving average; battery has own filter setting
// - Config write loads every field at once
// - Host writes the whole config word each time
// - Host: temperature is twice code minus 94
// - Host scales supply, gate and regulator codes (host scales only the low gate code, bits 6:0)
// - Disable bit suppresses overheat shutdown action
// - Warning and shutdown kept as separate flags
//
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/1ns
`include "amc_regs.svh"
module amc_dev
#(
  parameter logic [6:0] OTW_CODE = 7'h5A,
  parameter logic [6:0] OTS_CODE = 7'h64
)
(
  // Clock, reset, enable
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic         clkEn,
  // Register link
  amc_link_if.dev           lnk,
  // Device state and converter core
  input  wire logic         deviceActive,
  input  wire logic         convDone,
  input  wire logic [6:0]   convCode,
  output logic              convStart,
  output amc_pkg::amc_src_t convSel,
  // Protection
  output logic              overheatWarning,
  output logic              overheatShutdown
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (OTW_CODE > OTS_CODE)
  begin : gChk
    $error("Warning threshold must not exceed shutdown threshold");
  end

  amc_pkg::amc_dev_state_t s;
  amc_pkg::amc_dev_state_t n;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Fixed loop order; batt every other slot
  function automatic amc_pkg::amc_src_t slotSrc(input logic [2:0] slot);
    case (slot)
      3'h1:    slotSrc = amc_pkg::SRC_TEMP;
      3'h3:    slotSrc = amc_pkg::SRC_LOWG;
      3'h5:    slotSrc = amc_pkg::SRC_HIGHG;
      default: slotSrc = amc_pkg::SRC_BATT;
    endcase
  endfunction

  // Select code 3 is unused and falls back to the buck output
  function automatic amc_pkg::amc_src_t extraSrc(input logic [1:0] sel);
    case (sel)
      2'h0:    extraSrc = amc_pkg::SRC_CURR;
      2'h1:    extraSrc = amc_pkg::SRC_LREG;
      default: extraSrc = amc_pkg::SRC_BUCK;
    endcase
  endfunction

  // History row of a source; all extra sources share row 4
  function automatic logic [2:0] rowOf(input amc_pkg::amc_src_t src);
    case (src)
      amc_pkg::SRC_BATT:  rowOf = 3'h0;
      amc_pkg::SRC_TEMP:  rowOf = 3'h1;
      amc_pkg::SRC_LOWG:  rowOf = 3'h2;
      amc_pkg::SRC_HIGHG: rowOf = 3'h3;
      default:            rowOf = 3'h4;
    endcase
  endfunction

  // Average of the newest 2^cfg samples, recomputed so a config change acts at once
  function automatic logic [6:0] avgRow(input logic [7:0][6:0] row, input logic [1:0] cfg);
    logic [9:0] sum;
    int         i;
    sum = 10'h000;
    for (i = 0; i < `AMC_FILT_MAX; i++)
    begin
      if (i < (1 << cfg))
        sum = sum + {3'h0, row[i]};
    end
    avgRow = 7'(sum >> cfg);
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic [2:0]       row;
  logic [7:0][6:0]  newRow;
  logic [6:0]       filt;

  // Register port, sequencer and protection in one pass
  always_comb
  begin
    n           = s;
    n.convStart = 1'b0;
    n.regAck    = 1'b0;
    row         = rowOf(s.convSel);
    newRow      = {s.hist[row][6:0], convCode};
    filt        = avgRow(newRow, (row == 3'h0) ? s.battFilt : s.sharedFilt);

    // Sequencer
    case (s.seq)
      amc_pkg::SQ_IDLE:
      begin
        if (deviceActive)
          n.seq = amc_pkg::SQ_START;
      end
      amc_pkg::SQ_START:
      begin
        n.convStart = 1'b1;
        n.seq       = amc_pkg::SQ_WAIT;
        if (s.odReq)
        begin
          n.curExtra = 1'b1;
          n.convSel  = extraSrc(s.odSel);
          n.odReq    = 1'b0;
        end
        else
        begin
          n.curExtra = 1'b0;
          n.convSel  = slotSrc(s.slot);
        end
      end
      amc_pkg::SQ_WAIT:
      begin
        // A request waits here until the running conversion ends
        if (convDone)
        begin
          n.seq      = amc_pkg::SQ_START;
          n.hist[row] = newRow;
          if (s.curExtra)
          begin
            n.odVal = filt;
            n.odRdy = 1'b1;
          end
          else
          begin
            // Slot pointer only moves on loop conversions
            n.slot = (s.slot == `AMC_SLOT_COUNT - 3'h1) ? 3'h0 : s.slot + 3'h1;
            case (s.convSel)
              amc_pkg::SRC_BATT:  n.battCode = filt;
              amc_pkg::SRC_TEMP:  n.tempCode = filt;
              amc_pkg::SRC_LOWG:  n.lowCode  = filt;
              default:            n.highCode = filt;
            endcase
          end
        end
      end
      default: n.seq = amc_pkg::SQ_IDLE;
    endcase

    // Leaving active abandons everything and rewinds the loop
    if (!deviceActive)
    begin
      n.seq      = amc_pkg::SQ_IDLE;
      n.slot     = 3'h0;
      n.odReq    = 1'b0;
      n.curExtra = 1'b0;
    end

    // Register access; one access per request, answered next edge
    if (lnk.regReq && !s.regAck)
    begin
      n.regAck = 1'b1;
      case (lnk.regAddr)
        `AMC_REG_CONV_CFG:   n.regRdata = {9'h000, s.sharedFilt, s.battFilt, s.odReq, s.odSel};
        `AMC_REG_RESULT_ST:  n.regRdata = {8'h00, s.odRdy, s.odVal};
        `AMC_REG_SUPPLY:     n.regRdata = {9'h000, s.battCode};
        `AMC_REG_CPUMP_ST:   n.regRdata = {1'b0, s.highCode, 1'b0, s.lowCode};
        `AMC_REG_TEMP:       n.regRdata = {6'h00, s.otsFlag, s.otwFlag, 1'b0, s.tempCode};
        `AMC_REG_SENSOR_CFG: n.regRdata = {15'h0000, s.otsDis};
        default:             n.regRdata = 16'h0000;
      endcase
      if (lnk.regWe)
      begin
        case (lnk.regAddr)
          `AMC_REG_CONV_CFG:
          begin
            // Every field is taken from the word; nothing is merged
            n.odSel      = lnk.regWdata[`AMC_CFG_SEL_LSB +: 2];
            n.battFilt   = lnk.regWdata[`AMC_CFG_BFILT_LSB +: 2];
            n.sharedFilt = lnk.regWdata[`AMC_CFG_SFILT_LSB +: 2];
            n.odReq      = lnk.regWdata[`AMC_CFG_REQ_BIT] && deviceActive;
            if (lnk.regWdata[`AMC_CFG_REQ_BIT])
              n.odRdy = 1'b0;
          end
          `AMC_REG_TEMP:
          begin
            // Write one to clear a fault flag
            if (lnk.regWdata[`AMC_TEMP_OTW_BIT])
              n.otwFlag = 1'b0;
            if (lnk.regWdata[`AMC_TEMP_OTS_BIT])
              n.otsFlag = 1'b0;
          end
          `AMC_REG_SENSOR_CFG: n.otsDis = lnk.regWdata[`AMC_SENS_DIS_BIT];
          default: ;
        endcase
      end
    end

    // Protection from the filtered temperature; set wins over a clear
    n.otwOut = (s.tempCode >= OTW_CODE);
    n.otsOut = (s.tempCode >= OTS_CODE) && !s.otsDis;
    if (s.tempCode >= OTW_CODE)
      n.otwFlag = 1'b1;
    if (s.tempCode >= OTS_CODE)
      n.otsFlag = 1'b1;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Reset first; clock enable low freezes everything
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      s            <= '0;
      s.seq        <= amc_pkg::SQ_IDLE;
      s.convSel    <= amc_pkg::SRC_BATT;
      s.odSel      <= 2'(`AMC_CFG_RESET >> `AMC_CFG_SEL_LSB);
      s.battFilt   <= 2'(`AMC_CFG_RESET >> `AMC_CFG_BFILT_LSB);
      s.sharedFilt <= 2'(`AMC_CFG_RESET >> `AMC_CFG_SFILT_LSB);
      s.otsDis     <= `AMC_SENS_RESET;
    end
    else if (clkEn)
      s <= n;
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign lnk.regAck       = s.regAck;
  assign lnk.regRdata     = s.regRdata;
  assign convStart        = s.convStart;
  assign convSel          = s.convSel;
  assign overheatWarning  = s.otwOut;
  assign overheatShutdown = s.otsOut;

endmodule // amc_dev

// ### amc_regs.svh
// Register offsets, field positions, reset values and counts of the converter monitor
`ifndef AMC_REGS_SVH
`define AMC_REGS_SVH

// ----------------------------------------------------------------
// Device register indices (link register port, 16-bit words)
// ----------------------------------------------------------------
`define AMC_REG_CONV_CFG     4'h0
`define AMC_REG_RESULT_ST    4'h1
`define AMC_REG_SUPPLY       4'h2
`define AMC_REG_CPUMP_ST     4'h3
`define AMC_REG_TEMP         4'h4
`define AMC_REG_SENSOR_CFG   4'h5

// ----------------------------------------------------------------
// Device field positions and reset values
// ----------------------------------------------------------------
`define AMC_CFG_SEL_LSB      0
`define AMC_CFG_REQ_BIT      2
`define AMC_CFG_BFILT_LSB    3
`define AMC_CFG_SFILT_LSB    5
`define AMC_CFG_RESET        16'h0000
`define AMC_RES_RDY_BIT      7
`define AMC_CP_HIGH_LSB      8
`define AMC_TEMP_OTW_BIT     8
`define AMC_TEMP_OTS_BIT     9
`define AMC_SENS_DIS_BIT     0
`define AMC_SENS_RESET       1'b0
`define AMC_SLOT_COUNT       3'h6
`define AMC_FILT_MAX         8

// ----------------------------------------------------------------
// Host APB register byte offsets
// ----------------------------------------------------------------
`define AMC_APB_CTRL         8'h00
`define AMC_APB_WDATA        8'h04
`define AMC_APB_STATUS       8'h08
`define AMC_APB_SCALED       8'h0C
`define AMC_APB_WRITE_BIT    8
`define AMC_APB_DONE_BIT     1
`define AMC_APB_RDATA_LSB    16

// ----------------------------------------------------------------
// Host scaling constants
// ----------------------------------------------------------------
`define AMC_TEMP_STEP        2
`define AMC_TEMP_OFFSET      94
`define AMC_BATT_SLOPE_UV    581
`define AMC_BATT_OFFSET_MV   5520
`define AMC_GATE_FULL_MV     16000
`define AMC_CODE_FULL        127

`endif

// ### amc_pkg.sv
// Types shared by both ends of the converter monitor
package amc_pkg;

  // ----------------------------------------------------------------
  // Conversion sources
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SRC_BATT  = 3'h0,
    SRC_TEMP  = 3'h1,
    SRC_LOWG  = 3'h2,
    SRC_HIGHG = 3'h3,
    SRC_CURR  = 3'h4,
    SRC_LREG  = 3'h5,
    SRC_BUCK  = 3'h6
  } amc_src_t;

  // ----------------------------------------------------------------
  // State machines
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SQ_IDLE  = 3'b001,
    SQ_START = 3'b010,
    SQ_WAIT  = 3'b100
  } amc_seq_t;

  typedef enum logic [1:0] {
    HS_IDLE = 2'b01,
    HS_REQ  = 2'b10
  } amc_hseq_t;

  // ----------------------------------------------------------------
  // Whole state of the device end
  // ----------------------------------------------------------------
  typedef struct packed {
    amc_seq_t            seq;
    logic [2:0]          slot;
    logic                curExtra;
    logic [1:0]          odSel;
    logic                odReq;
    logic [1:0]          battFilt;
    logic [1:0]          sharedFilt;
    logic                otsDis;
    logic [6:0]          odVal;
    logic                odRdy;
    logic [6:0]          battCode;
    logic [6:0]          tempCode;
    logic [6:0]          lowCode;
    logic [6:0]          highCode;
    logic                otwFlag;
    logic                otsFlag;
    logic                convStart;
    amc_src_t            convSel;
    logic                otwOut;
    logic                otsOut;
    logic                regAck;
    logic [15:0]         regRdata;
    logic [4:0][7:0][6:0] hist;
  } amc_dev_state_t;

  // ----------------------------------------------------------------
  // Whole state of the host end
  // ----------------------------------------------------------------
  typedef struct packed {
    amc_hseq_t   seq;
    logic [3:0]  cmdAddr;
    logic        cmdWrite;
    logic [15:0] cmdWdata;
    logic        done;
    logic [15:0] rdata;
    logic [31:0] scaled;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        regReq;
    logic        regWe;
    logic [3:0]  regAddr;
    logic [15:0] regWdata;
  } amc_host_state_t;

endpackage

// ### amc_link_if.sv
// Register link between the monitor device and its controlling host
`timescale 1ns/1ns
interface amc_link_if;
  logic        regReq;
  logic        regWe;
  logic [3:0]  regAddr;
  logic [15:0] regWdata;
  logic [15:0] regRdata;
  logic        regAck;

  modport dev
  (
    input  regReq,
    input  regWe,
    input  regAddr,
    input  regWdata,
    output regRdata,
    output regAck
  );

  modport host
  (
    output regReq,
    output regWe,
    output regAddr,
    output regWdata,
    input  regRdata,
    input  regAck
  );
endinterface

// ### amc_host.sv
// Host end: APB-controlled register master for the converter monitor
`timescale 1ns/1ns
`include "amc_regs.svh"
module amc_host
#(
  parameter int REG_TARGET_MV = 3300
)
(
  // Clock, reset, enable
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        clkEn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Register link
  amc_link_if.host         lnk
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (REG_TARGET_MV <= 0 || REG_TARGET_MV > 65535)
  begin : gChk
    $error("Regulator target out of range");
  end

  amc_pkg::amc_host_state_t s;
  amc_pkg::amc_host_state_t n;

  // Physical value of a code by the register it came from: degC or mV
  function automatic logic [31:0] scaleCode(input logic [3:0] addr, input logic [15:0] d);
    logic signed [31:0] c;
    c = signed'({25'h0, d[6:0]});
    case (addr)
      `AMC_REG_TEMP:      scaleCode = 32'(`AMC_TEMP_STEP * c - `AMC_TEMP_OFFSET);
      `AMC_REG_SUPPLY:    scaleCode = 32'(`AMC_BATT_SLOPE_UV * c + `AMC_BATT_OFFSET_MV);
      `AMC_REG_CPUMP_ST:  scaleCode = 32'(c * `AMC_GATE_FULL_MV / `AMC_CODE_FULL);
      `AMC_REG_RESULT_ST: scaleCode = 32'(c * REG_TARGET_MV / `AMC_CODE_FULL);
      default:            scaleCode = 32'h00000000;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic mapped;
  logic busy;

  // APB answer, command launch and link completion
  always_comb
  begin
    n      = s;
    busy   = (s.seq == amc_pkg::HS_REQ);
    mapped = (paddr == `AMC_APB_CTRL) || (paddr == `AMC_APB_WDATA) ||
             (paddr == `AMC_APB_STATUS) || (paddr == `AMC_APB_SCALED);
    n.pready = 1'b0;

    // First access cycle prepares the answer; the following edge completes it
    if (psel && penable && !s.pready)
    begin
      n.pready  = 1'b1;
      n.pslverr = !mapped;
      case (paddr)
        `AMC_APB_CTRL:   n.prdata = {23'h000000, s.cmdWrite, 4'h0, s.cmdAddr};
        `AMC_APB_WDATA:  n.prdata = {16'h0000, s.cmdWdata};
        `AMC_APB_STATUS: n.prdata = {s.rdata, 14'h0000, s.done, busy};
        `AMC_APB_SCALED: n.prdata = s.scaled;
        default:         n.prdata = 32'h00000000;
      endcase
    end

    // Write takes effect at the edge where pready is seen high
    if (psel && penable && s.pready && pwrite && !s.pslverr)
    begin
      case (paddr)
        `AMC_APB_WDATA: n.cmdWdata = pwdata[15:0];
        `AMC_APB_CTRL:
        begin
          // Ignored while a link access is outstanding
          if (!busy)
          begin
            n.cmdAddr  = pwdata[3:0];
            n.cmdWrite = pwdata[`AMC_APB_WRITE_BIT];
            n.done     = 1'b0;
            n.seq      = amc_pkg::HS_REQ;
            n.regReq   = 1'b1;
            n.regWe    = pwdata[`AMC_APB_WRITE_BIT];
            n.regAddr  = pwdata[3:0];
            n.regWdata = s.cmdWdata;
          end
        end
        default: ;
      endcase
    end

    // Link completion
    case (s.seq)
      amc_pkg::HS_IDLE: ;
      amc_pkg::HS_REQ:
      begin
        if (lnk.regAck)
        begin
          n.seq    = amc_pkg::HS_IDLE;
          n.regReq = 1'b0;
          n.regWe  = 1'b0;
          n.done   = 1'b1;
          n.rdata  = lnk.regRdata;
          n.scaled = scaleCode(s.regAddr, lnk.regRdata);
        end
      end
      default: n.seq = amc_pkg::HS_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      s     <= '0;
      s.seq <= amc_pkg::HS_IDLE;
    end
    else if (clkEn)
      s <= n;
  end

  // ----------------------------------------------------------------
  // Outputs from the state register
  // ----------------------------------------------------------------
  assign prdata       = s.prdata;
  assign pready       = s.pready;
  assign pslverr      = s.pslverr;
  assign lnk.regReq   = s.regReq;
  assign lnk.regWe    = s.regWe;
  assign lnk.regAddr  = s.regAddr;
  assign lnk.regWdata = s.regWdata;

endmodule // amc_host

// ### amc_monitor.sv
// Link handshake and register-width checker for the converter monitor
`timescale 1ns/1ns
`include "amc_regs.svh"
module amc_monitor
(
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // Link signals
  input wire logic        regReq,
  input wire logic        regWe,
  input wire logic [3:0]  regAddr,
  input wire logic [15:0] regWdata,
  input wire logic [15:0] regRdata,
  input wire logic        regAck
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // Handshake steps
  // ----------------------------------------------------------------
  sequence sTake;
    regReq && !regAck;
  endsequence
  sequence sAnswer;
    regAck ##1 !regAck;
  endsequence

  // Ack is a single pulse one cycle after a request is taken
  AST_ANSWER: assert property (sTake |=> sAnswer)
    else $error("link answer missing or too long");
  AST_ACK_CAUSE: assert property (regAck |-> $past(regReq) && !$past(regAck))
    else $error("link ack without request");
  // Host keeps the whole word steady until answered
  AST_REQ_HOLD: assert property
    (sTake |=> regReq && $stable({regWe, regAddr, regWdata}))
    else $error("link request changed before ack");
  AST_REQ_DROP: assert property (regAck |=> !regReq)
    else $error("link request not released after ack");
  // Read words carry 7-bit codes and documented flags only
  AST_RESULT_BITS: assert property
    (regAck && regAddr == `AMC_REG_RESULT_ST |-> regRdata[15:8] == 8'h00)
    else $error("extra result word has stray bits");
  AST_SUPPLY_BITS: assert property
    (regAck && regAddr == `AMC_REG_SUPPLY |-> regRdata[15:7] == 9'h000)
    else $error("supply word has stray bits");
  AST_CPUMP_BITS: assert property
    (regAck && regAddr == `AMC_REG_CPUMP_ST |-> !regRdata[15] && !regRdata[7])
    else $error("gate supply word has stray bits");
  AST_TEMP_BITS: assert property
    (regAck && regAddr == `AMC_REG_TEMP |-> regRdata[15:10] == 6'h00 && !regRdata[7])
    else $error("temperature word has stray bits");
  AST_SENS_BITS: assert property
    (regAck && regAddr == `AMC_REG_SENSOR_CFG |-> regRdata[15:1] == 15'h0000)
    else $error("sensor config word has stray bits");
endmodule // amc_monitor

// ### tb.sv
// Self-checking bench joining both ends of the converter monitor
`timescale 1ns/1ns
`include "amc_regs.svh"
module tb;
  // ----------------------------------------------------------------
  // Signals and model state
  // ----------------------------------------------------------------
  logic              clk_sys, rst, psel, penable, pwrite, deviceActive, convDone;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata;
  logic              pready, pslverr, convStart, overheatWarning, overheatShutdown;
  logic [6:0]        convCode;
  amc_pkg::amc_src_t convSel;
  logic [15:0]       lfsr, q;
  logic [6:0]        last [8];
  int                miscompares, checks_done, cyc, slot, xExp, starts;
  bit                hold, hot;
  amc_link_if        link ();

  amc_host amc_host_i (.clk_sys(clk_sys), .rst(rst), .clkEn(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lnk(link.host));
  amc_dev amc_dev_i (.clk_sys(clk_sys), .rst(rst), .clkEn(1'b1), .lnk(link.dev),
    .deviceActive(deviceActive), .convDone(convDone), .convCode(convCode),
    .convStart(convStart), .convSel(convSel), .overheatWarning(overheatWarning),
    .overheatShutdown(overheatShutdown));
  amc_monitor amc_monitor_i (.clk_sys(clk_sys), .rst(rst), .regReq(link.regReq),
    .regWe(link.regWe), .regAddr(link.regAddr), .regWdata(link.regWdata),
    .regRdata(link.regRdata), .regAck(link.regAck));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] step(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Loop order: battery on even slots, then temp, low gate, high gate
  function automatic logic [31:0] order(input int s);
    return (s % 2 == 0) ? 32'h0 : 32'((s + 1) / 2);
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer; held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Device register access through the host, polled to completion
  task automatic acc(input logic w, input logic [3:0] i, input logic [15:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, `AMC_APB_WDATA, {16'h0000, d}, r, e);
    apb(1'b1, `AMC_APB_CTRL, {23'h000000, w, 4'h0, i}, r, e);
    do
      apb(1'b0, `AMC_APB_STATUS, 32'h0, r, e);
    while (r[1:0] !== 2'b10);
    q = r[31:16];
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock, timeout and converter stand-in
  // ----------------------------------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // Ceiling on run length
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      miscompares++;
      summarize();
    end
  end
  // Answers each start after a random delay; stalls while hold is set
  initial
  begin
    convDone = 1'b0;
    convCode = 7'h00;
    forever
    begin
      @(posedge clk_sys);
      if (convStart === 1'b1)
      begin
        starts++;
        if (convSel >= amc_pkg::SRC_CURR)
          chk("extra source", 32'(convSel), xExp);
        else
        begin
          chk("slot source", 32'(convSel), order(slot));
          slot = (slot + 1) % 6;
        end
        repeat (lfsr[1:0]) @(posedge clk_sys);
        while (hold && deviceActive) @(posedge clk_sys);
        if (deviceActive)
        begin
          lfsr = step(lfsr);
          if (convSel == 0) last[7] = last[0]; // Older battery code
          last[convSel] = (convSel != 1) ? lfsr[6:0] : hot ? 7'h64 : {1'b0, lfsr[5:0]};
          convDone <= 1'b1;
          convCode <= last[convSel];
          @(posedge clk_sys);
          convDone <= 1'b0;
          if (convSel >= amc_pkg::SRC_CURR)
            xExp = -1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [31:0] r;
    logic        e;
    int          k;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    deviceActive = 1'b0;
    lfsr = 16'h7684;
    xExp = -1;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    // Reset contents, unmapped places, nothing converted while inactive
    for (int i = 0; i < 16; i++)
    begin
      acc(1'b0, 4'(i), 16'h0000);
      chk("reset word", 32'(q), 32'h0);
    end
    apb(1'b0, 8'h10, 32'h0, r, e);
    chk("apb unmapped error", 32'(e), 32'h1);
    chk("starts while inactive", starts, 32'h0);
    $display("end test reset");
    deviceActive <= 1'b1;
    repeat (300) @(posedge clk_sys);
    // Every extra select code; select 3 reads as buck
    for (int s = 0; s < 4; s++)
    begin
      xExp = (s == 0) ? 4 : (s == 1) ? 5 : 6;
      k = xExp;
      acc(1'b1, `AMC_REG_CONV_CFG, 16'(s + 12));
      for (int n = 0; n < 300 && xExp != -1; n++) @(posedge clk_sys);
      chk("extra done", xExp, -1);
      hold = 1'b1;
      acc(1'b0, `AMC_REG_RESULT_ST, 16'h0000);
      chk("extra result", 32'(q), {24'h000000, 1'b1, last[k]});
      apb(1'b0, `AMC_APB_SCALED, 32'h0, r, e);
      chk("extra scaled", r, 32'(int'(last[k]) * 3300 / 127));
      acc(1'b0, `AMC_REG_CONV_CFG, 16'h0000);
      chk("request self clear", 32'(q), 32'(s + 8));
      hold = 1'b0;
    end
    $display("end test extra");
    // Status words and host scaling with the loop stalled
    hold = 1'b1;
    acc(1'b0, `AMC_REG_SUPPLY, 16'h0000);
    k = (int'(last[0]) + last[7]) / 2;
    chk("supply word", 32'(q), k);
    apb(1'b0, `AMC_APB_SCALED, 32'h0, r, e);
    chk("supply scaled", r, 32'(581 * k + 5520));
    acc(1'b0, `AMC_REG_CPUMP_ST, 16'h0000);
    chk("gate word", 32'(q), {17'h0, last[3], 1'b0, last[2]});
    acc(1'b0, `AMC_REG_TEMP, 16'h0000);
    chk("temp word", 32'(q), 32'(last[1]));
    apb(1'b0, `AMC_APB_SCALED, 32'h0, r, e);
    chk("temp scaled", r, 32'(2 * int'(last[1]) - 94));
    hold = 1'b0;
    $display("end test status");
    // Overheat: both flags, then shutdown suppressed by the disable bit
    hot = 1'b1;
    for (int n = 0; n < 400 && overheatShutdown !== 1'b1; n++) @(posedge clk_sys);
    repeat (2) @(posedge clk_sys);
    chk("shutdown out", 32'(overheatShutdown), 32'h1);
    chk("warning out", 32'(overheatWarning), 32'h1);
    hold = 1'b1;
    acc(1'b0, `AMC_REG_TEMP, 16'h0000);
    chk("temp flags", 32'(q), 32'h0364);
    acc(1'b1, `AMC_REG_SENSOR_CFG, 16'h0001);
    repeat (3) @(posedge clk_sys);
    chk("shutdown disabled", 32'(overheatShutdown), 32'h0);
    hot = 1'b0;
    $display("end test overheat");
    // Leave active with a request written; restart must begin at slot zero
    deviceActive <= 1'b0;
    repeat (2) @(posedge clk_sys);
    k = starts;
    acc(1'b1, `AMC_REG_CONV_CFG, 16'h0004);
    repeat (20) @(posedge clk_sys);
    chk("starts after leaving", starts, k);
    slot = 0;
    hold = 1'b0;
    deviceActive <= 1'b1;
    repeat (300) @(posedge clk_sys);
    chk("no stale extra", xExp, -1);
    $display("end test reentry");
    summarize();
  end
endmodule // tb
